// >>> shared/ctdc_cfg.svh
`ifndef CTDC_CFG_SVH
`define CTDC_CFG_SVH

// ----------------------------------------
// Clocking
// ----------------------------------------
`define CTDC_CLK_HZ 40000000
`define CTDC_F10_HZ 10000000
`define CTDC_F1_HZ 1000000

// ----------------------------------------
// Register word indices, byte address = 4 * index
// ----------------------------------------
`define CTDC_IDX_CNT0 6'h04
`define CTDC_IDX_CNT1 6'h05
`define CTDC_IDX_CNT2 6'h06
`define CTDC_IDX_CTRL 6'h07
`define CTDC_IDX_SRC 6'h08
`define CTDC_IDX_STAT 6'h09

// ----------------------------------------
// Control byte fields
// ----------------------------------------
`define CTDC_SC_HI 7
`define CTDC_SC_LO 6
`define CTDC_FMT_HI 5
`define CTDC_FMT_LO 4
`define CTDC_MODE_HI 3
`define CTDC_MODE_LO 1
`define CTDC_BCD_BIT 0
`define CTDC_SC_RDBK 2'h3
`define CTDC_RB_NOCNT 5
`define CTDC_RB_SEL0 1

// ----------------------------------------
// Source control fields
// ----------------------------------------
`define CTDC_CAS_LO 0
`define CTDC_CAS_HI 1
`define CTDC_CKSEL0 2
`define CTDC_CKSEL1 3
`define CTDC_CKSEL2 4

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define CTDC_SRC_RST 8'h00
`define CTDC_OUT_RST 1'b0
`define CTDC_CNT_RST 16'h0000
`define CTDC_CNT_ONE 16'h0001
`define CTDC_CNT_TWO 16'h0002

`endif

// >>> shared/ctdc_pkg.sv
package ctdc_pkg;
  typedef enum logic [2:0] {
    CTDC_M0_TC = 3'h0,
    CTDC_M1_OS = 3'h1,
    CTDC_M2_RATE = 3'h2,
    CTDC_M3_SQ = 3'h3,
    CTDC_M4_SWS = 3'h4,
    CTDC_M5_HWS = 3'h5
  } ctdc_mode_e;
  typedef enum logic [1:0] {
    CTDC_F_LATCH = 2'h0,
    CTDC_F_LSB = 2'h1,
    CTDC_F_MSB = 2'h2,
    CTDC_F_LSB_MSB = 2'h3
  } ctdc_fmt_e;
  typedef logic [15:0] ctdc_count_t;
endpackage

// >>> src/ctdc_counter.sv
`timescale 1ns/100ps
`include "ctdc_cfg.svh"

module ctdc_counter (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic tick_in,
  input wire logic gate_in,
  input wire logic cfg_in,
  input ctdc_pkg::ctdc_mode_e mode_in,
  input wire logic bcd_in,
  input wire logic load_in,
  input ctdc_pkg::ctdc_count_t load_val_in,
  output ctdc_pkg::ctdc_count_t count_out,
  output logic out_out,
  output logic tc_out
);
  import ctdc_pkg::*;

  ctdc_mode_e mode;
  logic bcd;
  logic run;
  logic trig;
  logic gate_q;
  ctdc_count_t reload;
  ctdc_count_t dec_1;
  ctdc_count_t dec_2;
  logic gate_rise;
  logic gate_ok;
  logic trig_mode;
  logic adv;

  // ----------------------------------------
  // Decrement, binary or decimal
  // ----------------------------------------
  function automatic ctdc_count_t dec_fn(input ctdc_count_t v,
                                         input logic b);
    ctdc_count_t r;
    logic brw;
    brw = 1'b1;
    r = v - `CTDC_CNT_ONE;
    if (b) begin
      r = v;
      for (int i = 0; i < 4; i++) begin
        if (brw) begin
          if (r[4*i +: 4] == 4'h0) begin
            r[4*i +: 4] = 4'h9;
          end else begin
            r[4*i +: 4] = r[4*i +: 4] - 4'h1;
            brw = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  assign dec_1 = dec_fn(count_out, bcd);
  assign dec_2 = dec_fn(dec_1, bcd);
  assign gate_rise = gate_in & ~gate_q;
  assign trig_mode = (mode != CTDC_M0_TC) && (mode != CTDC_M4_SWS);
  // One-shot modes keep counting with the gate low
  assign gate_ok = gate_in | (mode == CTDC_M1_OS)
    | (mode == CTDC_M5_HWS);
  assign adv = tick_in & run & gate_ok & ~trig;

  // ----------------------------------------
  // Configuration and trigger capture
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode <= CTDC_M0_TC;
      bcd <= 1'b0;
    end else if (cfg_in) begin
      mode <= mode_in;
      bcd <= bcd_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reload <= `CTDC_CNT_RST;
    end else if (load_in) begin
      reload <= load_val_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      gate_q <= 1'b1;
    end else begin
      gate_q <= gate_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in || cfg_in) begin
      trig <= 1'b0;
    end else if (gate_rise && trig_mode) begin
      trig <= 1'b1;
    end else if (tick_in) begin
      trig <= 1'b0;
    end
  end

  // ----------------------------------------
  // Count and output
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count_out <= `CTDC_CNT_RST;
      out_out <= `CTDC_OUT_RST;
      run <= 1'b0;
    end else if (cfg_in) begin
      run <= 1'b0;
      out_out <= (mode_in != CTDC_M0_TC);
    end else if (load_in) begin
      unique case (mode)
        CTDC_M0_TC: begin
          count_out <= load_val_in;
          out_out <= 1'b0;
          run <= 1'b1;
        end
        CTDC_M2_RATE, CTDC_M3_SQ, CTDC_M4_SWS: begin
          count_out <= load_val_in;
          out_out <= 1'b1;
          run <= 1'b1;
        end
        CTDC_M1_OS, CTDC_M5_HWS: begin
          run <= 1'b0;
        end
        default: begin
          run <= 1'b0;
        end
      endcase
    end else if (tick_in && trig) begin
      count_out <= reload;
      run <= 1'b1;
      out_out <= (mode != CTDC_M1_OS);
    end else if (adv) begin
      unique case (mode)
        CTDC_M0_TC: begin
          count_out <= dec_1;
          if (count_out == `CTDC_CNT_ONE) begin
            out_out <= 1'b1;
          end
        end
        CTDC_M1_OS: begin
          count_out <= dec_1;
          if (count_out == `CTDC_CNT_ONE) begin
            out_out <= 1'b1;
            run <= 1'b0;
          end
        end
        CTDC_M2_RATE: begin
          if (count_out == `CTDC_CNT_ONE) begin
            count_out <= reload;
            out_out <= 1'b1;
          end else begin
            count_out <= dec_1;
            out_out <= (count_out != `CTDC_CNT_TWO);
          end
        end
        CTDC_M3_SQ: begin
          if (count_out <= `CTDC_CNT_TWO) begin
            out_out <= ~out_out;
            count_out <= out_out ? {reload[15:1], 1'b0} : reload;
          end else begin
            count_out <= dec_2;
          end
        end
        CTDC_M4_SWS, CTDC_M5_HWS: begin
          if (!out_out) begin
            out_out <= 1'b1;
            run <= 1'b0;
          end else begin
            count_out <= dec_1;
            if (count_out == `CTDC_CNT_ONE) begin
              out_out <= 1'b0;
            end
          end
        end
        default: begin
          run <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tc_out <= 1'b0;
    end else begin
      tc_out <= adv && (count_out == `CTDC_CNT_ONE);
    end
  end
endmodule

// >>> src/ctdc_top.sv
`timescale 1ns/100ps
`include "ctdc_cfg.svh"

module ctdc_top #(
  parameter int N_CNT = 3
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic CYC_IN,
  input wire logic STB_IN,
  input wire logic WE_IN,
  input wire logic [7:0] ADR_IN,
  input wire logic [3:0] SEL_IN,
  input wire logic [31:0] DAT_IN,
  output logic [31:0] DAT_OUT,
  output logic ACK_OUT,
  input wire logic CNT0_CLK_IN,
  input wire logic CNT2_CLK_IN,
  input wire logic GATE0_IN,
  input wire logic GATE2_IN,
  output logic [2:0] COUNT_OUT
);
  import ctdc_pkg::*;

  localparam int DIV10 = `CTDC_CLK_HZ / `CTDC_F10_HZ;
  localparam int DIV1 = `CTDC_CLK_HZ / `CTDC_F1_HZ;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic acc;
  logic wr;
  logic rd;
  logic [5:0] idx;
  logic [7:0] wbyte;
  logic ctrl_wr;
  logic [1:0] sc;
  ctdc_fmt_e fmt_wr;
  ctdc_mode_e mode_wr;

  assign acc = CYC_IN & STB_IN & ~ACK_OUT;
  assign wr = acc & WE_IN & SEL_IN[0];
  assign rd = acc & ~WE_IN;
  assign idx = ADR_IN[7:2];
  assign wbyte = DAT_IN[7:0];
  assign ctrl_wr = wr && (idx == `CTDC_IDX_CTRL);
  assign sc = wbyte[`CTDC_SC_HI:`CTDC_SC_LO];
  assign fmt_wr = ctdc_fmt_e'(wbyte[`CTDC_FMT_HI:`CTDC_FMT_LO]);
  // Modes 2 and 3 ignore the top mode bit
  assign mode_wr = wbyte[`CTDC_MODE_LO + 1]
    ? ctdc_mode_e'({1'b0, wbyte[`CTDC_MODE_LO + 1:`CTDC_MODE_LO]})
    : ctdc_mode_e'(wbyte[`CTDC_MODE_HI:`CTDC_MODE_LO]);

  // ----------------------------------------
  // Source and cascade control
  // ----------------------------------------
  logic [7:0] src;
  logic cas_32;
  logic cas_48;

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      src <= `CTDC_SRC_RST;
    end else if (wr && (idx == `CTDC_IDX_SRC)) begin
      src <= wbyte;
    end
  end

  // Code 11 selects neither chain
  assign cas_32 = src[`CTDC_CAS_LO] & ~src[`CTDC_CAS_HI];
  assign cas_48 = src[`CTDC_CAS_HI] & ~src[`CTDC_CAS_LO];

  // ----------------------------------------
  // Internal rate ticks
  // ----------------------------------------
  logic [7:0] pre10;
  logic [7:0] pre1;
  logic tick10;
  logic tick1;

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      pre10 <= 8'h00;
      tick10 <= 1'b0;
    end else if (pre10 == 8'(DIV10 - 1)) begin
      pre10 <= 8'h00;
      tick10 <= 1'b1;
    end else begin
      pre10 <= pre10 + 8'h01;
      tick10 <= 1'b0;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      pre1 <= 8'h00;
      tick1 <= 1'b0;
    end else if (pre1 == 8'(DIV1 - 1)) begin
      pre1 <= 8'h00;
      tick1 <= 1'b1;
    end else begin
      pre1 <= pre1 + 8'h01;
      tick1 <= 1'b0;
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [1:0] clk_s3;
  logic ext0_rise;
  logic ext2_rise;
  logic [2:0] gate;

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      pin_s1 <= 4'hF;
      pin_s2 <= 4'hF;
      clk_s3 <= 2'h3;
    end else begin
      pin_s1 <= {GATE2_IN, GATE0_IN, CNT2_CLK_IN, CNT0_CLK_IN};
      pin_s2 <= pin_s1;
      clk_s3 <= pin_s2[1:0];
    end
  end

  assign ext0_rise = pin_s2[0] & ~clk_s3[0];
  assign ext2_rise = pin_s2[1] & ~clk_s3[1];
  // Gates rest high unless the far end pulls 0 or 2 low
  assign gate[0] = pin_s2[2];
  assign gate[1] = 1'b1;
  assign gate[2] = pin_s2[3];

  // ----------------------------------------
  // Count sources
  // ----------------------------------------
  logic [2:0] tick;
  logic [2:0] tc;
  ctdc_count_t live [N_CNT];
  logic [2:0] cnt_out;

  assign tick[0] = src[`CTDC_CKSEL0] ? ext0_rise : tick10;
  assign tick[1] = cas_48 ? tc[0]
    : (src[`CTDC_CKSEL1] ? tick1 : tick10);
  assign tick[2] = (cas_32 | cas_48) ? tc[1]
    : (src[`CTDC_CKSEL2] ? ext2_rise : tick1);

  // ----------------------------------------
  // Per-counter access logic
  // ----------------------------------------
  ctdc_fmt_e fmt [N_CNT];
  ctdc_mode_e mode [N_CNT];
  logic [N_CNT-1:0] bcd;
  logic [N_CNT-1:0] latched;
  logic [N_CNT-1:0] rd_hi;
  logic [N_CNT-1:0] wr_hi;
  logic [N_CNT-1:0] cfg_p;
  logic [N_CNT-1:0] load_p;
  logic [7:0] wr_lo [N_CNT];
  ctdc_count_t hold [N_CNT];
  ctdc_count_t load_v [N_CNT];
  logic [7:0] rd_byte [N_CNT];

  genvar g;
  generate
    for (g = 0; g < N_CNT; g++) begin : g_cnt
      logic hit;
      logic lat_req;
      logic sel_cmd;
      ctdc_count_t src_val;

      assign hit = idx == (`CTDC_IDX_CNT0 + 6'(g));
      assign sel_cmd = ctrl_wr && (sc == 2'(g));
      assign lat_req = (sel_cmd && (fmt_wr == CTDC_F_LATCH))
        || (ctrl_wr && (sc == `CTDC_SC_RDBK)
        && !wbyte[`CTDC_RB_NOCNT] && wbyte[`CTDC_RB_SEL0 + g]);
      assign src_val = latched[g] ? hold[g] : live[g];
      assign rd_byte[g] = (fmt[g] == CTDC_F_MSB
        || (fmt[g] == CTDC_F_LSB_MSB && rd_hi[g]))
        ? src_val[15:8] : src_val[7:0];

      // Mode, format and number base
      always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
          fmt[g] <= CTDC_F_LSB_MSB;
          mode[g] <= CTDC_M0_TC;
          bcd[g] <= 1'b0;
          cfg_p[g] <= 1'b0;
        end else begin
          cfg_p[g] <= sel_cmd && (fmt_wr != CTDC_F_LATCH);
          if (sel_cmd && (fmt_wr != CTDC_F_LATCH)) begin
            fmt[g] <= fmt_wr;
            mode[g] <= mode_wr;
            bcd[g] <= wbyte[`CTDC_BCD_BIT];
          end
        end
      end

      // Hold register; a second latch keeps the first value
      always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
          latched[g] <= 1'b0;
          hold[g] <= `CTDC_CNT_RST;
        end else if (sel_cmd && (fmt_wr != CTDC_F_LATCH)) begin
          latched[g] <= 1'b0;
        end else if (lat_req && !latched[g]) begin
          latched[g] <= 1'b1;
          hold[g] <= live[g];
        end else if (rd && hit && latched[g]
                     && !(fmt[g] == CTDC_F_LSB_MSB && !rd_hi[g])) begin
          latched[g] <= 1'b0;
        end
      end

      // Read byte sequence
      always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
          rd_hi[g] <= 1'b0;
        end else if (sel_cmd && (fmt_wr != CTDC_F_LATCH)) begin
          rd_hi[g] <= 1'b0;
        end else if (rd && hit && (fmt[g] == CTDC_F_LSB_MSB)) begin
          rd_hi[g] <= ~rd_hi[g];
        end
      end

      // Load byte sequence
      always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
          wr_hi[g] <= 1'b0;
          wr_lo[g] <= 8'h00;
          load_p[g] <= 1'b0;
          load_v[g] <= `CTDC_CNT_RST;
        end else begin
          load_p[g] <= 1'b0;
          if (sel_cmd && (fmt_wr != CTDC_F_LATCH)) begin
            wr_hi[g] <= 1'b0;
          end else if (wr && hit) begin
            unique case (fmt[g])
              CTDC_F_LSB: begin
                load_v[g] <= {8'h00, wbyte};
                load_p[g] <= 1'b1;
              end
              CTDC_F_MSB: begin
                load_v[g] <= {wbyte, 8'h00};
                load_p[g] <= 1'b1;
              end
              CTDC_F_LSB_MSB: begin
                if (!wr_hi[g]) begin
                  wr_lo[g] <= wbyte;
                  wr_hi[g] <= 1'b1;
                end else begin
                  load_v[g] <= {wbyte, wr_lo[g]};
                  load_p[g] <= 1'b1;
                  wr_hi[g] <= 1'b0;
                end
              end
              CTDC_F_LATCH: begin
                load_p[g] <= 1'b0;
              end
            endcase
          end
        end
      end

      ctdc_counter u_cnt (
        .clk_in(CLK_IN),
        .rst_in(RST_IN),
        .tick_in(tick[g]),
        .gate_in(gate[g]),
        .cfg_in(cfg_p[g]),
        .mode_in(mode[g]),
        .bcd_in(bcd[g]),
        .load_in(load_p[g]),
        .load_val_in(load_v[g]),
        .count_out(live[g]),
        .out_out(cnt_out[g]),
        .tc_out(tc[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      ACK_OUT <= 1'b0;
    end else begin
      ACK_OUT <= acc;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      DAT_OUT <= 32'h00000000;
    end else if (rd) begin
      unique case (idx)
        `CTDC_IDX_CNT0: DAT_OUT <= {24'h000000, rd_byte[0]};
        `CTDC_IDX_CNT1: DAT_OUT <= {24'h000000, rd_byte[1]};
        `CTDC_IDX_CNT2: DAT_OUT <= {24'h000000, rd_byte[2]};
        `CTDC_IDX_SRC: DAT_OUT <= {24'h000000, src};
        `CTDC_IDX_STAT: DAT_OUT <= {26'h0, gate, cnt_out};
        default: DAT_OUT <= 32'h00000000;
      endcase
    end else begin
      DAT_OUT <= 32'h00000000;
    end
  end

  // ----------------------------------------
  // Counter output pins
  // ----------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      COUNT_OUT <= {3{`CTDC_OUT_RST}};
    end else begin
      COUNT_OUT <= cnt_out;
    end
  end
endmodule

// >>> verification/ctdc_top_assertions.sv
`timescale 1ns/100ps
module ctdc_chk #(
  parameter int N_CNT = 3
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic CYC_IN,
  input wire logic STB_IN,
  input wire logic WE_IN,
  input wire logic [7:0] ADR_IN,
  input wire logic [31:0] DAT_OUT,
  input wire logic ACK_OUT,
  input wire logic [2:0] COUNT_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  property p_ack_taken;
    CYC_IN && STB_IN && !ACK_OUT |=> ACK_OUT;
  endproperty
  a_ack_taken: assert property (p_ack_taken) else $error("no ack");
  property p_ack_pulse;
    ACK_OUT |=> !ACK_OUT;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
  property p_ack_cause;
    ACK_OUT |-> $past(CYC_IN && STB_IN);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  property p_dat_idle;
    !ACK_OUT |-> DAT_OUT == 32'h00000000;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data idle");
  property p_dat_byte;
    DAT_OUT[31:8] == 24'h000000;
  endproperty
  a_dat_byte: assert property (p_dat_byte) else $error("wide data");
  property p_ctrl_rd;
    ACK_OUT && $past(!WE_IN && ADR_IN[7:2] == 6'h07) |-> DAT_OUT == 32'h0;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("ctrl read");
  property p_gate1;
    ACK_OUT && $past(!WE_IN && ADR_IN[7:2] == 6'h09) |-> DAT_OUT[4];
  endproperty
  a_gate1: assert property (p_gate1) else $error("gate1 low");
  property p_out_rst;
    $past(RST_IN) |-> COUNT_OUT == 3'h0 ##1 !ACK_OUT;
  endproperty
  a_out_rst: assert property (p_out_rst) else $error("reset out");
  c_wr: cover property (ACK_OUT && $past(WE_IN));
  c_rd: cover property (ACK_OUT && !$past(WE_IN));
  c_out1: cover property ($rose(COUNT_OUT[1]));
endmodule
bind ctdc_top ctdc_chk #(.N_CNT(N_CNT)) ctdc_chk_i (.CLK_IN, .RST_IN,
  .CYC_IN, .STB_IN, .WE_IN, .ADR_IN, .DAT_OUT, .ACK_OUT, .COUNT_OUT);

// >>> verification/ctdc_host.sv
`timescale 1ns/100ps
module ctdc_host (
  input wire logic clk_in,
  input wire logic ack_in,
  input wire logic [31:0] dat_in,
  output logic cyc_out,
  output logic stb_out,
  output logic we_out,
  output logic [7:0] adr_out,
  output logic [3:0] sel_out,
  output logic [31:0] dat_out
);
  initial begin
    cyc_out = 1'b0;
    stb_out = 1'b0;
    we_out = 1'b0;
    adr_out = 8'h00;
    sel_out = 4'h0;
    dat_out = 32'h0;
  end
  // One byte access, held until ack; released lines show garbage
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [7:0] d, output logic [31:0] q);
    @(posedge clk_in);
    cyc_out <= 1'b1;
    stb_out <= 1'b1;
    we_out <= w;
    adr_out <= a;
    sel_out <= 4'h1;
    dat_out <= {24'h000000, d};
    do @(posedge clk_in); while (ack_in !== 1'b1);
    q = dat_in;
    cyc_out <= 1'b0;
    stb_out <= 1'b0;
    adr_out <= ~a;
    dat_out <= ~{24'h000000, d};
  endtask
endmodule

// >>> verification/testbench.sv
`timescale 1ns/100ps
module testbench;
  import ctdc_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cnt0_clk = 1'b0;
  logic cnt2_clk = 1'b0;
  logic gate0 = 1'b1;
  logic gate2 = 1'b1;
  logic cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dw, dr, q;
  logic [2:0] cnt;
  logic [15:0] v, v1;
  logic [7:0] mtab [4] = '{8'h74, 8'h7C, 8'h76, 8'h7E};
  int n_errors = 0;
  int n_tests = 0;
  int ticks = 0;
  int n, t, k;
  int mq[$];
  ctdc_top ctdc_top_i (.CLK_IN(clk_in), .RST_IN(rst_in), .CYC_IN(cyc),
    .STB_IN(stb), .WE_IN(we), .ADR_IN(adr), .SEL_IN(sel), .DAT_IN(dw),
    .DAT_OUT(dr), .ACK_OUT(ack), .CNT0_CLK_IN(cnt0_clk),
    .CNT2_CLK_IN(cnt2_clk), .GATE0_IN(gate0), .GATE2_IN(gate2),
    .COUNT_OUT(cnt));
  ctdc_host ctdc_host_i (.clk_in(clk_in), .ack_in(ack), .dat_in(dr),
    .cyc_out(cyc), .stb_out(stb), .we_out(we), .adr_out(adr),
    .sel_out(sel), .dat_out(dw));
  initial forever #12.5 clk_in = ~clk_in;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task test_done;
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk_in) begin
    ticks <= ticks + 1;
    if (ticks == 30000) begin
      n_errors = n_errors + 1;
      $display("[ERR] %0t timeout", $time);
      test_done();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] ca(input int c);
    return 8'h10 + 8'(4 * c);
  endfunction
  // Decimal digits of a count, as the counter should hold them
  function automatic logic [15:0] m_bcd(input int d);
    return {4'(d / 1000 % 10), 4'(d / 100 % 10), 4'(d / 10 % 10),
      4'(d % 10)};
  endfunction
  task wr(input logic [7:0] a, input logic [7:0] d);
    ctdc_host_i.xfer(1'b1, a, d, q);
  endtask
  task rd(input logic [7:0] a);
    ctdc_host_i.xfer(1'b0, a, 8'h00, q);
  endtask
  task rd16(input int c);
    logic [7:0] lo;
    rd(ca(c));
    lo = q[7:0];
    rd(ca(c));
    v = {q[7:0], lo};
  endtask
  task ld(input int c, input logic [7:0] m, input logic [15:0] x);
    wr(8'h1C, m);
    wr(ca(c), x[7:0]);
    wr(ca(c), x[15:8]);
  endtask
  task till(input int b, input logic lv);
    n = 0;
    while (cnt[b] !== lv && n < 3000) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 3000) begin
      n_errors++;
      $display("[ERR] %0t no edge on output %0d", $time, b);
    end
  endtask
  task cyc_wait(input int c);
    repeat (c) @(posedge clk_in);
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    void'($urandom(32'hFCE9));
    cyc_wait(5);
    rst_in <= 1'b0;
    rd(8'h20);
    chk(q, 32'h0);
    rd(8'h24);
    chk(q[4], 1'b1);
    rd(8'hFC);
    chk(q, 32'h0);
    $display("test reset done");
    k = 5 + $urandom % 16;
    ld(1, 8'h70, 16'(k));
    cyc_wait(3);
    chk(cnt[1], 1'b0);
    till(1, 1'b1);
    chk(n >= 4 * k - 4 && n <= 4 * k + 4, 1'b1);
    cyc_wait(200);
    chk(cnt[1], 1'b1);
    $display("test terminal count done");
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 3; j++) begin
        k = (j == 0) ? 2 : (j == 1) ? 3 : 4 + $urandom % 9;
        ld(1, mtab[i], 16'(k));
        till(1, 1'b0);
        till(1, 1'b1);
        till(1, 1'b0);
        t = n;
        till(1, 1'b1);
        chk(t + n, 4 * k);
        chk(t, (i < 2) ? 4 * (k - 1) : 4 * ((k + 1) / 2));
        chk(n, (i < 2) ? 4 : 4 * (k / 2));
      end
    end
    $display("test periodic done");
    ld(1, 8'h78, 16'h0009);
    cyc_wait(3);
    chk(cnt[1], 1'b1);
    till(1, 1'b0);
    chk(n >= 30 && n <= 40, 1'b1);
    till(1, 1'b1);
    chk(n, 4);
    $display("test soft strobe done");
    gate0 <= 1'b0;
    k = 100 + $urandom % 60000;
    ld(0, 8'h30, 16'(k));
    cyc_wait(8);
    wr(8'h1C, 8'h00);
    gate0 <= 1'b1;
    cyc_wait(100);
    rd16(0);
    chk(v, k[15:0]);
    gate0 <= 1'b0;
    cyc_wait(8);
    rd16(0);
    v1 = v;
    cyc_wait(100);
    rd16(0);
    chk(v, v1);
    chk(k - v1 >= 20 && k - v1 <= 40, 1'b1);
    $display("test latch and gate done");
    ld(0, 8'h32, 16'h000A);
    cyc_wait(8);
    chk(cnt[0], 1'b1);
    gate0 <= 1'b1;
    till(0, 1'b0);
    chk(n <= 12, 1'b1);
    till(0, 1'b1);
    chk(n, 40);
    gate0 <= 1'b0;
    cyc_wait(4);
    gate0 <= 1'b1;
    till(0, 1'b0);
    cyc_wait(16);
    gate0 <= 1'b0;
    cyc_wait(4);
    gate0 <= 1'b1;
    till(0, 1'b1);
    chk(n >= 36, 1'b1);
    gate0 <= 1'b0;
    ld(0, 8'h3A, 16'h0006);
    cyc_wait(4);
    gate0 <= 1'b1;
    till(0, 1'b0);
    chk(n >= 24 && n <= 36, 1'b1);
    till(0, 1'b1);
    chk(n, 4);
    gate0 <= 1'b0;
    cyc_wait(4);
    gate0 <= 1'b1;
    cyc_wait(12);
    gate0 <= 1'b0;
    cyc_wait(4);
    gate0 <= 1'b1;
    till(0, 1'b0);
    chk(n >= 24 && n <= 36, 1'b1);
    $display("test one shot done");
    gate2 <= 1'b0;
    k = $urandom;
    mq.push_back(k[7:0]);
    mq.push_back(k[15:8]);
    wr(8'h1C, 8'h90);
    wr(8'h18, k[7:0]);
    rd(8'h18);
    chk(q[7:0], mq.pop_front());
    wr(8'h1C, 8'hA0);
    wr(8'h18, k[15:8]);
    rd(8'h18);
    chk(q[7:0], mq.pop_front());
    gate2 <= 1'b1;
    $display("test byte formats done");
    for (int c = 0; c < 4; c++) begin
      wr(8'h20, 8'h10 | 8'(c));
      rd(8'h20);
      chk(q[4:0], 5'h10 | 5'(c));
      wr(8'h1C, 8'h30);
      wr(8'h1C, 8'h70);
      ld(2, 8'hB0, 16'h0005);
      ld(1, 8'h70, 16'h0001);
      ld(0, 8'h30, 16'h0001);
      cyc_wait(60);
      wr(8'h1C, 8'h80);
      rd16(2);
      chk(v, (c == 1 || c == 2) ? 16'h0004 : 16'h0005);
    end
    $display("test cascade done");
    wr(8'h20, 8'h1C);
    ld(0, 8'h31, 16'h0100);
    ld(2, 8'hB1, 16'h0100);
    repeat (3) begin
      cnt0_clk <= 1'b1;
      cnt2_clk <= 1'b1;
      cyc_wait(5);
      cnt0_clk <= 1'b0;
      cnt2_clk <= 1'b0;
      cyc_wait(5);
    end
    wr(8'h1C, 8'hDA);
    rd16(0);
    chk(v, m_bcd(100 - 3));
    rd16(2);
    chk(v, m_bcd(100 - 3));
    $display("test decimal done");
    test_done();
  end
endmodule
